/* include/dp_pkg.sv */
package dp_pkg;

    localparam int unsigned DATA_W   = 8;
    localparam int unsigned PTR_W    = 16;
    localparam int unsigned FILE_AW  = 7;
    localparam int unsigned BANK_W   = 4;
    localparam int unsigned LATCH_W  = 7;
    localparam int unsigned OFFSET_W = 6;
    localparam int unsigned NUM_PTR  = 2;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] INSTR_OFS    = 8'h00;
    localparam logic [7:0] ACC_OFS      = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] BANK_OFS     = 8'h0C;
    localparam logic [7:0] LATCH_OFS    = 8'h10;
    localparam logic [7:0] PTR0_OFS     = 8'h14;
    localparam logic [7:0] PTR1_OFS     = 8'h18;
    localparam logic [7:0] MEM_ADDR_OFS = 8'h1C;
    localparam logic [7:0] MEM_DATA_OFS = 8'h20;

    // Values after reset.
    localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
    localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam logic [PTR_W-1:0]   PTR_RST   = 16'h0000;
    localparam logic [DATA_W-1:0]  MEM_RST   = 8'h00;

    // File addresses that are windows onto the two pointers.
    localparam logic [FILE_AW-1:0] WIN0_ADDR = 7'h00;
    localparam logic [FILE_AW-1:0] WIN1_ADDR = 7'h01;

    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [3:0] {
        nop_op                      = 4'h0,
        logical_shift_left_op       = 4'h1,
        logical_shift_right_op      = 4'h2,
        move_file_op                = 4'h3,
        indirect_to_accumulator_op  = 4'h4,
        indirect_offset_to_acc_op   = 4'h5,
        literal_to_bank_op          = 4'h6,
        literal_to_program_latch_op = 4'h7,
        literal_to_accumulator_op   = 4'h8,
        accumulator_to_file_op      = 4'h9
    } op_e;

    typedef enum logic [1:0] {
        upd_pre_inc  = 2'b00,
        upd_pre_dec  = 2'b01,
        upd_post_inc = 2'b10,
        upd_post_dec = 2'b11
    } pointer_update_mode_e;

    typedef struct packed {
        logic [15:0]          unused;
        op_e                  op;
        pointer_update_mode_e pointer_update_mode;
        logic                 ptr_sel;
        logic                 dest;
        logic [7:0]           literal;
    } instr_s;

    typedef struct packed {
        logic illegal;
        logic zero;
        logic carry;
    } status_s;

endpackage

/* rtl/logical_shift_unit.sv */
`timescale 1ns/10ps
module logical_shift_unit #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] src,
    input  wire logic             shift_left,
    output logic      [WIDTH-1:0] result,
    output logic                  carry_out
);

    always_comb begin
        if (shift_left) begin
            result    = {src[WIDTH-2:0], 1'b0};
            carry_out = src[WIDTH-1];
        end else begin
            result    = {1'b0, src[WIDTH-1:1]};
            carry_out = src[0];
        end
    end

endmodule

/* rtl/indirect_pointer_unit.sv */
`timescale 1ns/10ps
module indirect_pointer_unit #(
    parameter int unsigned PTR_W = 16,
    parameter int unsigned OFS_W = 6
) (
    input  wire logic [PTR_W-1:0]              ptr,
    input  wire dp_pkg::pointer_update_mode_e  mode,
    input  wire logic                          offset_form,
    input  wire logic [OFS_W-1:0]              offset,
    output logic      [PTR_W-1:0]              eff_addr,
    output logic      [PTR_W-1:0]              ptr_after
);

    logic [PTR_W-1:0] inc;
    logic [PTR_W-1:0] dec;
    logic [PTR_W-1:0] ofs_ext;

    // Plain modulo arithmetic at the pointer width gives the wrap at both ends.
    assign inc     = ptr + 1'b1;
    assign dec     = ptr - 1'b1;
    assign ofs_ext = {{(PTR_W-OFS_W){offset[OFS_W-1]}}, offset};

    always_comb begin
        if (offset_form) begin
            eff_addr  = ptr + ofs_ext;
            ptr_after = ptr;
        end else begin
            unique case (mode)
                dp_pkg::upd_pre_inc: begin
                    eff_addr  = inc;
                    ptr_after = inc;
                end
                dp_pkg::upd_pre_dec: begin
                    eff_addr  = dec;
                    ptr_after = dec;
                end
                dp_pkg::upd_post_inc: begin
                    eff_addr  = ptr;
                    ptr_after = inc;
                end
                dp_pkg::upd_post_dec: begin
                    eff_addr  = ptr;
                    ptr_after = dec;
                end
            endcase
        end
    end

endmodule

/* rtl/shift_move_instruction_datapath.sv */
`timescale 1ns/10ps
module shift_move_instruction_datapath #(
    parameter int unsigned FILE_DEPTH = 128,
    parameter int unsigned APB_AW     = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [3:0]        bank_select_register,
    output logic      [6:0]        program_counter_high_latch
);

    localparam int unsigned NP = dp_pkg::NUM_PTR;

    logic [7:0]         acc_ff;
    logic [7:0]         nxt_acc;
    dp_pkg::status_s    status_ff;
    dp_pkg::status_s    nxt_status;
    logic [3:0]         bank_ff;
    logic [3:0]         nxt_bank;
    logic [6:0]         latch_ff;
    logic [6:0]         nxt_latch;
    logic [15:0]        ptr_ff [NP];
    logic [15:0]        nxt_ptr [NP];
    logic [6:0]         mem_addr_ff;
    logic [6:0]         nxt_mem_addr;
    logic [7:0]         mem_ff [FILE_DEPTH];
    logic [7:0]         nxt_mem [FILE_DEPTH];
    dp_pkg::instr_s     last_instr_ff;
    dp_pkg::instr_s     nxt_last_instr;
    logic [31:0]        prdata_ff;
    logic [31:0]        nxt_prdata;
    logic               pslverr_ff;
    logic               nxt_pslverr;

    logic               setup_phase;
    logic               wr_access;
    logic [7:0]         reg_addr;
    logic               exec;
    dp_pkg::instr_s     instr;
    logic [15:0]        eff_addr [NP];
    logic [15:0]        ptr_after [NP];
    logic [7:0]         file_src;
    logic [7:0]         shift_res;
    logic               shift_carry;

    assign setup_phase = psel & ~penable;
    assign wr_access   = psel & penable & pwrite;
    assign reg_addr    = 8'(paddr);
    assign instr       = dp_pkg::instr_s'(pwdata);
    // An instruction needs both low byte lanes; a partial write is dropped.
    assign exec        = wr_access && (reg_addr == dp_pkg::INSTR_OFS) && (pstrb[1:0] == 2'b11);

    // Zero wait states: read data is captured in the setup cycle.
    assign pready                     = 1'b1;
    assign prdata                     = prdata_ff;
    assign pslverr                    = pslverr_ff & psel & penable;
    assign bank_select_register       = bank_ff;
    assign program_counter_high_latch = latch_ff;

    // Window addresses hold no storage, so an indirect access that lands on
    // one reads zero and writes nothing instead of recursing.
    function automatic logic data_ok(input logic [15:0] a);
        data_ok = (a >= 16'(NP)) && (a < 16'(FILE_DEPTH));
    endfunction

    function automatic logic [7:0] data_read(input logic [15:0] a);
        data_read = data_ok(a) ? mem_ff[a[6:0]] : 8'h00;
    endfunction

    function automatic logic [15:0] file_target(input logic [6:0] f);
        if (f == dp_pkg::WIN0_ADDR) begin
            file_target = ptr_ff[0];
        end else if (f == dp_pkg::WIN1_ADDR) begin
            file_target = ptr_ff[1];
        end else begin
            file_target = {9'h000, f};
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == dp_pkg::INSTR_OFS) || (a == dp_pkg::ACC_OFS) ||
                 (a == dp_pkg::STATUS_OFS) || (a == dp_pkg::BANK_OFS) ||
                 (a == dp_pkg::LATCH_OFS) || (a == dp_pkg::PTR0_OFS) ||
                 (a == dp_pkg::PTR1_OFS) || (a == dp_pkg::MEM_ADDR_OFS) ||
                 (a == dp_pkg::MEM_DATA_OFS);
    endfunction

    always_comb file_src = data_read(file_target(instr.literal[6:0]));

    for (genvar g = 0; g < NP; g++) begin : g_ptr
        indirect_pointer_unit #(
            .PTR_W (dp_pkg::PTR_W),
            .OFS_W (dp_pkg::OFFSET_W)
        ) u_ptr (
            .ptr         (ptr_ff[g]),
            .mode        (instr.pointer_update_mode),
            .offset_form (instr.op == dp_pkg::indirect_offset_to_acc_op),
            .offset      (instr.literal[5:0]),
            .eff_addr    (eff_addr[g]),
            .ptr_after   (ptr_after[g])
        );
    end

    logical_shift_unit #(
        .WIDTH (dp_pkg::DATA_W)
    ) u_shift (
        .src        (file_src),
        .shift_left (instr.op == dp_pkg::logical_shift_left_op),
        .result     (shift_res),
        .carry_out  (shift_carry)
    );

    always_comb begin
        logic [31:0] wm;
        logic [7:0]  res;
        logic [15:0] tgt;
        logic        wb_file;
        logic        wb_acc;
        wm             = 32'h0000_0000;
        res            = 8'h00;
        tgt            = 16'h0000;
        wb_file        = 1'b0;
        wb_acc         = 1'b0;
        nxt_acc        = acc_ff;
        nxt_status     = status_ff;
        nxt_bank       = bank_ff;
        nxt_latch      = latch_ff;
        nxt_ptr        = ptr_ff;
        nxt_mem_addr   = mem_addr_ff;
        nxt_mem        = mem_ff;
        nxt_last_instr = last_instr_ff;

        if (wr_access && !exec) begin
            unique case (reg_addr)
                dp_pkg::ACC_OFS: begin
                    wm      = merge({24'h000000, acc_ff}, pwdata, pstrb);
                    nxt_acc = wm[7:0];
                end
                dp_pkg::STATUS_OFS: begin
                    wm               = merge({29'h0, status_ff}, pwdata, pstrb);
                    nxt_status.carry = wm[0];
                    nxt_status.zero  = wm[1];
                end
                dp_pkg::BANK_OFS: begin
                    wm       = merge({28'h0, bank_ff}, pwdata, pstrb);
                    nxt_bank = wm[3:0];
                end
                dp_pkg::LATCH_OFS: begin
                    wm        = merge({25'h0, latch_ff}, pwdata, pstrb);
                    nxt_latch = wm[6:0];
                end
                dp_pkg::PTR0_OFS: begin
                    wm         = merge({16'h0000, ptr_ff[0]}, pwdata, pstrb);
                    nxt_ptr[0] = wm[15:0];
                end
                dp_pkg::PTR1_OFS: begin
                    wm         = merge({16'h0000, ptr_ff[1]}, pwdata, pstrb);
                    nxt_ptr[1] = wm[15:0];
                end
                dp_pkg::MEM_ADDR_OFS: begin
                    wm           = merge({25'h0, mem_addr_ff}, pwdata, pstrb);
                    nxt_mem_addr = wm[6:0];
                end
                dp_pkg::MEM_DATA_OFS: begin
                    wm = merge({24'h000000, mem_ff[mem_addr_ff]}, pwdata, pstrb);
                    if (data_ok({9'h000, mem_addr_ff})) begin
                        nxt_mem[mem_addr_ff] = wm[7:0];
                    end
                end
                default: begin
                    wm = 32'h0000_0000;
                end
            endcase
        end

        if (exec) begin
            nxt_last_instr     = instr;
            nxt_status.illegal = 1'b0;
            tgt                = file_target(instr.literal[6:0]);
            unique case (instr.op)
                dp_pkg::nop_op: begin
                    res = 8'h00;
                end
                dp_pkg::logical_shift_left_op, dp_pkg::logical_shift_right_op: begin
                    res              = shift_res;
                    nxt_status.carry = shift_carry;
                    nxt_status.zero  = (shift_res == 8'h00);
                    wb_file          = (instr.dest == dp_pkg::DEST_FILE);
                    wb_acc           = (instr.dest == dp_pkg::DEST_ACC);
                end
                dp_pkg::move_file_op: begin
                    res             = file_src;
                    nxt_status.zero = (file_src == 8'h00);
                    wb_file         = (instr.dest == dp_pkg::DEST_FILE);
                    wb_acc          = (instr.dest == dp_pkg::DEST_ACC);
                end
                dp_pkg::indirect_to_accumulator_op, dp_pkg::indirect_offset_to_acc_op: begin
                    res                      = data_read(eff_addr[instr.ptr_sel]);
                    nxt_status.zero          = (res == 8'h00);
                    wb_acc                   = 1'b1;
                    nxt_ptr[instr.ptr_sel]   = ptr_after[instr.ptr_sel];
                end
                dp_pkg::literal_to_bank_op: begin
                    nxt_bank = instr.literal[3:0];
                end
                dp_pkg::literal_to_program_latch_op: begin
                    nxt_latch = instr.literal[6:0];
                end
                dp_pkg::literal_to_accumulator_op: begin
                    nxt_acc = instr.literal;
                end
                dp_pkg::accumulator_to_file_op: begin
                    res     = acc_ff;
                    wb_file = 1'b1;
                end
                default: begin
                    nxt_status.illegal = 1'b1;
                end
            endcase
            if (wb_acc) begin
                nxt_acc = res;
            end
            if (wb_file && data_ok(tgt)) begin
                nxt_mem[tgt[6:0]] = res;
            end
        end
    end

    always_comb begin
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        if (setup_phase) begin
            nxt_pslverr = ~mapped(reg_addr);
            unique case (reg_addr)
                dp_pkg::INSTR_OFS:    nxt_prdata = 32'(last_instr_ff);
                dp_pkg::ACC_OFS:      nxt_prdata = {24'h000000, acc_ff};
                dp_pkg::STATUS_OFS:   nxt_prdata = {29'h0, status_ff};
                dp_pkg::BANK_OFS:     nxt_prdata = {28'h0, bank_ff};
                dp_pkg::LATCH_OFS:    nxt_prdata = {25'h0, latch_ff};
                dp_pkg::PTR0_OFS:     nxt_prdata = {16'h0000, ptr_ff[0]};
                dp_pkg::PTR1_OFS:     nxt_prdata = {16'h0000, ptr_ff[1]};
                dp_pkg::MEM_ADDR_OFS: nxt_prdata = {25'h0, mem_addr_ff};
                dp_pkg::MEM_DATA_OFS: nxt_prdata = {24'h000000, data_read({9'h000, mem_addr_ff})};
                default:              nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff        <= dp_pkg::ACC_RST;
            status_ff     <= '0;
            bank_ff       <= dp_pkg::BANK_RST;
            latch_ff      <= dp_pkg::LATCH_RST;
            mem_addr_ff   <= '0;
            last_instr_ff <= '0;
            prdata_ff     <= 32'h0000_0000;
            pslverr_ff    <= 1'b0;
            for (int i = 0; i < NP; i++) begin
                ptr_ff[i] <= dp_pkg::PTR_RST;
            end
            for (int i = 0; i < FILE_DEPTH; i++) begin
                mem_ff[i] <= dp_pkg::MEM_RST;
            end
        end else begin
            acc_ff        <= nxt_acc;
            status_ff     <= nxt_status;
            bank_ff       <= nxt_bank;
            latch_ff      <= nxt_latch;
            mem_addr_ff   <= nxt_mem_addr;
            last_instr_ff <= nxt_last_instr;
            prdata_ff     <= nxt_prdata;
            pslverr_ff    <= nxt_pslverr;
            ptr_ff        <= nxt_ptr;
            mem_ff        <= nxt_mem;
        end
    end

endmodule

/* test/dp_props.sv */
`timescale 1ns/10ps
module dp_props #(
    parameter int unsigned APB_AW = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [3:0]        bank_select_register,
    input wire logic [6:0]        program_counter_high_latch
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic acc_ph;
    logic instr_wr;
    logic unmapped;
    assign acc_ph   = psel && penable;
    assign unmapped = paddr > APB_AW'(8'h20);
    // A partial-lane instruction write is refused, so it must not count as an execute.
    assign instr_wr = acc_ph && pwrite && paddr == APB_AW'(dp_pkg::INSTR_OFS)
                      && pstrb[1:0] == 2'h3;

    pready_high_a: assert property (pready)
        else $error("ready dropped");
    slverr_phase_a: assert property (pslverr |-> acc_ph)
        else $error("error flag outside access phase");
    unmapped_err_a: assert property (acc_ph && unmapped |-> pslverr)
        else $error("unmapped access without error");
    unmapped_zero_a: assert property (acc_ph && unmapped && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    mapped_ok_a: assert property (acc_ph && !unmapped && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    bank_load_a: assert property (
        instr_wr && pwdata[15:12] == dp_pkg::literal_to_bank_op
        |=> bank_select_register == $past(pwdata[3:0]))
        else $error("bank select not loaded");
    latch_load_a: assert property (
        instr_wr && pwdata[15:12] == dp_pkg::literal_to_program_latch_op
        |=> program_counter_high_latch == $past(pwdata[6:0]))
        else $error("program latch not loaded");
    bank_hold_a: assert property (
        !(instr_wr && pwdata[15:12] == dp_pkg::literal_to_bank_op)
        |=> $stable(bank_select_register))
        else $error("bank select changed without load");
    latch_hold_a: assert property (
        !(instr_wr && pwdata[15:12] == dp_pkg::literal_to_program_latch_op)
        |=> $stable(program_counter_high_latch))
        else $error("program latch changed without load");
    rdata_hold_a: assert property (acc_ph && !pwrite ##1 !psel |-> $stable(prdata))
        else $error("read data not held while idle");

    cover property (instr_wr && pwdata[15:12] == dp_pkg::literal_to_bank_op);
    cover property (acc_ph && unmapped && !pwrite);
    cover property (acc_ph && pwrite && paddr == APB_AW'(dp_pkg::INSTR_OFS) && pstrb != 4'hF);
endmodule

bind shift_move_instruction_datapath dp_props #(.APB_AW(APB_AW)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank_select_register(bank_select_register),
    .program_counter_high_latch(program_counter_high_latch));

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [15:0] ins;
        logic [6:0]  fa;
        logic [7:0]  fv;
        logic [7:0]  acc0;
        logic [1:0]  st0;
        logic [15:0] p0;
        logic [7:0]  x_acc;
        logic [1:0]  x_st;
        logic [7:0]  x_mem;
        logic [15:0] x_ptr;
    } row_s;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  bank_select_register;
    logic [6:0]  program_counter_high_latch;
    logic [31:0] rd;
    logic        err;
    row_s        r;
    int          failures     = 0;
    int          total_checks = 0;

    // Status values are written as {zero, carry}.
    row_s rows [20] = '{
        '{16'h0000, 7'h20, 8'h11, 8'h33, 2'h3, 16'h1234, 8'h33, 2'h3, 8'h11, 16'h1234},
        '{16'h1020, 7'h20, 8'h81, 8'h00, 2'h0, 16'h0000, 8'h02, 2'h1, 8'h81, 16'h0000},
        '{16'h1121, 7'h21, 8'h80, 8'h55, 2'h0, 16'h0000, 8'h55, 2'h3, 8'h00, 16'h0000},
        '{16'h2022, 7'h22, 8'h01, 8'h00, 2'h0, 16'h0000, 8'h00, 2'h3, 8'h01, 16'h0000},
        '{16'h2123, 7'h23, 8'hFE, 8'h11, 2'h3, 16'h0000, 8'h11, 2'h0, 8'h7F, 16'h0000},
        '{16'h3024, 7'h24, 8'h00, 8'h33, 2'h1, 16'h0000, 8'h00, 2'h3, 8'h00, 16'h0000},
        '{16'h3125, 7'h25, 8'h9C, 8'h44, 2'h2, 16'h0000, 8'h44, 2'h0, 8'h9C, 16'h0000},
        '{16'h4000, 7'h31, 8'hA5, 8'h00, 2'h2, 16'h0030, 8'hA5, 2'h0, 8'hA5, 16'h0031},
        '{16'h4400, 7'h31, 8'h00, 8'h77, 2'h1, 16'h0032, 8'h00, 2'h3, 8'h00, 16'h0031},
        '{16'h4800, 7'h40, 8'h3C, 8'h00, 2'h0, 16'h0040, 8'h3C, 2'h0, 8'h3C, 16'h0041},
        '{16'h4C00, 7'h50, 8'h7E, 8'h00, 2'h0, 16'h0050, 8'h7E, 2'h0, 8'h7E, 16'h004F},
        '{16'h5020, 7'h40, 8'h12, 8'h00, 2'h0, 16'h0060, 8'h12, 2'h0, 8'h12, 16'h0060},
        '{16'h501F, 7'h5F, 8'h00, 8'h66, 2'h0, 16'h0040, 8'h00, 2'h2, 8'h00, 16'h0040},
        '{16'h4400, 7'h2A, 8'h2A, 8'h55, 2'h0, 16'h0000, 8'h00, 2'h2, 8'h2A, 16'hFFFF},
        '{16'h4800, 7'h2A, 8'h2A, 8'h55, 2'h0, 16'hFFFF, 8'h00, 2'h2, 8'h2A, 16'h0000},
        '{16'h3000, 7'h35, 8'hC3, 8'h00, 2'h2, 16'h0035, 8'hC3, 2'h0, 8'hC3, 16'h0035},
        '{16'h1100, 7'h36, 8'h40, 8'h21, 2'h0, 16'h0036, 8'h21, 2'h0, 8'h80, 16'h0036},
        '{16'h80FF, 7'h26, 8'h26, 8'h00, 2'h3, 16'h0000, 8'hFF, 2'h3, 8'h26, 16'h0000},
        '{16'h8000, 7'h26, 8'h26, 8'hAA, 2'h0, 16'h0000, 8'h00, 2'h0, 8'h26, 16'h0000},
        '{16'h907F, 7'h7F, 8'h00, 8'h5A, 2'h2, 16'h0000, 8'h5A, 2'h2, 8'h5A, 16'h0000}
    };
    logic [7:0] rst_regs [6] = '{dp_pkg::ACC_OFS, dp_pkg::STATUS_OFS, dp_pkg::BANK_OFS,
                                 dp_pkg::LATCH_OFS, dp_pkg::PTR0_OFS, dp_pkg::PTR1_OFS};

    shift_move_instruction_datapath #(
        .FILE_DEPTH (128),
        .APB_AW     (8)
    ) DUT (
        .pclk                       (pclk),
        .presetn                    (presetn),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .pstrb                      (pstrb),
        .prdata                     (prdata),
        .pready                     (pready),
        .pslverr                    (pslverr),
        .bank_select_register       (bank_select_register),
        .program_counter_high_latch (program_counter_high_latch)
    );

    initial begin
        forever #4 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Starts one edge late so that the previous release and this setup never share a step.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            failures++;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk_reg(nm, e, rd);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            wr(dp_pkg::PTR0_OFS, {16'h0, r.p0});
            wr(dp_pkg::ACC_OFS, {24'h0, r.acc0});
            wr(dp_pkg::STATUS_OFS, {30'h0, r.st0});
            wr(dp_pkg::MEM_ADDR_OFS, {25'h0, r.fa});
            wr(dp_pkg::MEM_DATA_OFS, {24'h0, r.fv});
            wr(dp_pkg::INSTR_OFS, {16'h0, r.ins});
            rdchk("acc", dp_pkg::ACC_OFS, {24'h0, r.x_acc});
            rdchk("status", dp_pkg::STATUS_OFS, {30'h0, r.x_st});
            rdchk("file", dp_pkg::MEM_DATA_OFS, {24'h0, r.x_mem});
            rdchk("ptr0", dp_pkg::PTR0_OFS, {16'h0, r.x_ptr});
            $display("test row %0d done", i);
        end

        wr(dp_pkg::STATUS_OFS, 32'h0000_0003);
        for (int k = 0; k < 2; k++) begin
            wr(dp_pkg::INSTR_OFS, k == 0 ? 32'h0000_600F : 32'h0000_6000);
            wr(dp_pkg::INSTR_OFS, k == 0 ? 32'h0000_707F : 32'h0000_7000);
            rdchk("bank", dp_pkg::BANK_OFS, k == 0 ? 32'h0000_000F : 32'h0);
            rdchk("latch", dp_pkg::LATCH_OFS, k == 0 ? 32'h0000_007F : 32'h0);
            chk_reg("bank pin", k == 0 ? 32'hF : 32'h0, 32'(bank_select_register));
            chk_reg("latch pin", k == 0 ? 32'h7F : 32'h0, 32'(program_counter_high_latch));
        end
        rdchk("status kept", dp_pkg::STATUS_OFS, 32'h0000_0003);
        rdchk("acc kept", dp_pkg::ACC_OFS, 32'h0000_005A);
        $display("test literal loads done");

        pstrb <= 4'hC;
        wr(dp_pkg::INSTR_OFS, 32'h0000_8077);
        pstrb <= 4'hF;
        rdchk("acc refused", dp_pkg::ACC_OFS, 32'h0000_005A);
        $display("test partial write done");

        wr(dp_pkg::PTR1_OFS, 32'h0000_0070);
        wr(dp_pkg::MEM_ADDR_OFS, 32'h0000_0070);
        wr(dp_pkg::MEM_DATA_OFS, 32'h0000_0099);
        wr(dp_pkg::INSTR_OFS, 32'h0000_4A00);
        rdchk("acc ptr1", dp_pkg::ACC_OFS, 32'h0000_0099);
        rdchk("ptr1", dp_pkg::PTR1_OFS, 32'h0000_0071);
        rdchk("ptr0 kept", dp_pkg::PTR0_OFS, 32'h0);
        $display("test second pointer done");

        wr(8'h40, 32'h0000_00FF);
        chk_bit("write error", 1'b1, err);
        xfer(8'h40, 1'b0, 32'h0);
        chk_reg("unmapped read", 32'h0, rd);
        chk_bit("read error", 1'b1, err);
        wr(dp_pkg::INSTR_OFS, 32'h0000_F000);
        xfer(dp_pkg::STATUS_OFS, 1'b0, 32'h0);
        chk_bit("illegal flag", 1'b1, rd[2]);
        wr(dp_pkg::INSTR_OFS, 32'h0000_0000);
        xfer(dp_pkg::STATUS_OFS, 1'b0, 32'h0);
        chk_bit("illegal cleared", 1'b0, rd[2]);
        $display("test refusals done");

        wr(dp_pkg::INSTR_OFS, 32'h0000_6005);
        wr(dp_pkg::INSTR_OFS, 32'h0000_7055);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_reg("bank in reset", 32'h0, {28'h0, bank_select_register});
        chk_reg("latch in reset", 32'h0, {25'h0, program_counter_high_latch});
        presetn <= 1'b1;
        foreach (rst_regs[i]) begin
            rdchk("reset value", rst_regs[i], 32'h0);
        end
        $display("test reset done");
        end_of_test();
    end
endmodule
